/* hw/multiply_accumulate_unit.sv */
`timescale 1ns/1ps
`include "mac_map.svh"
module multiply_accumulate_unit import mac_pkg::*; (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic ISSUE_VALID,
    input wire op_e ISSUE_OP,
    input wire logic ISSUE_LONG,
    input wire logic ISSUE_HI_A,
    input wire logic ISSUE_HI_B,
    input wire shift_e ISSUE_SHIFT,
    input wire logic [31:0] ISSUE_OPA,
    input wire logic [31:0] ISSUE_OPB,
    input wire logic ISSUE_WITH_LOAD,
    input wire logic ISSUE_USE_MASK,
    input wire logic [31:0] ISSUE_ADDR,
    output logic ISSUE_READY,
    output logic RESULT_VALID,
    output logic [31:0] RESULT_DATA,
    output logic CCR_VALID,
    output logic [3:0] CCR_FLAGS,
    output logic ADDR_VALID,
    output logic [31:0] MASKED_ADDR
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [31:0] acc; // accumulator
        logic [15:0] mask; // operand address mask
        logic [7:0] sr; // status: mode and flags
        stage_s s1; // operand stage
        logic [1:0] gap; // cycles issue stays blocked
        logic res_v; // store or multiply result
        logic [31:0] res;
        logic ccr_v; // condition code copy
        logic [3:0] condition_code_register;
        logic addr_v; // masked fetch address
        logic [31:0] addr;
    } st_s;
    // one packed struct holds every register of the unit except the product stage
    st_s q; // registered state
    st_s next_q; // next value

    // carrier between the operand stage and the product stage
    mac_if m ();

    // product stage sits between operand and accumulate stages
    mac_product u_product (
        .clk(CLK_SYS),
        .arst_n(ARST_N),
        .m(m.mult)
    );

    // the operand stage register feeds the array directly
    assign m.req = q.s1;

    // ****************************************
    // issue acceptance
    // ****************************************
    logic is_move; // register move instruction
    logic is_mac; // accumulating instruction
    logic take; // instruction accepted this cycle
    logic pipe_busy; // arithmetic still in flight

    always_comb begin
        // everything that is not arithmetic is a register move
        is_move = !(ISSUE_OP inside {OP_MAC, OP_MSAC, OP_MULS, OP_MULU});
        is_mac = ISSUE_OP inside {OP_MAC, OP_MSAC};
        // stage 1 or stage 2 still holds an instruction
        pipe_busy = q.s1.v || m.res.v;
        // moves wait for an empty pipe so old work finishes on old mode
        ISSUE_READY = (q.gap == 2'h0) && !(is_move && pipe_busy);
        // the offer is consumed on the edge where both are high
        take = ISSUE_VALID && ISSUE_READY;
    end

    // ****************************************
    // operand selection
    // ****************************************
    logic op_uns; // operands treated unsigned
    logic [33:0] ext_a; // extended operands
    logic [33:0] ext_b;

    // pick a half or the whole word and extend it once
    function automatic logic [32:0] pick(input logic [31:0] x, input logic hi,
                                         input logic lng, input logic uns);
        logic [15:0] h;
        h = hi ? x[31:16] : x[15:0];
        // long operands keep all 32 bits; words extend the chosen half
        if (lng) begin
            pick = {(!uns && x[31]), x};
        end else begin
            pick = {{17{!uns && h[15]}}, h};
        end
    endfunction : pick

    always_comb begin
        // integer multiplies take signedness from the opcode
        op_uns = is_mac ? q.sr[`SR_UNS] : (ISSUE_OP == OP_MULU);
        // both operands share one signedness, set by mode or opcode
        ext_a = {1'b0, pick(ISSUE_OPA, ISSUE_HI_A, ISSUE_LONG, op_uns)};
        ext_b = {1'b0, pick(ISSUE_OPB, ISSUE_HI_B, ISSUE_LONG, op_uns)};
    end

    // ****************************************
    // product scaling and accumulation
    // ****************************************
    stage_s r; // instruction leaving the array
    logic [63:0] wide; // fraction aligned product
    logic rnd_up; // round to nearest even
    logic [31:0] p32; // 32-bit product
    logic [31:0] psh; // shifted product
    logic [33:0] sum; // guarded accumulation
    logic ovf; // accumulation overflowed
    logic [31:0] sat_val; // saturation bound
    logic [31:0] acc_new; // final accumulator value

    always_comb begin
        r = m.res;
        // fractions carry a duplicate sign bit, so align by one place
        wide = {m.prod[62:0], 1'b0};
        // ties round only when the kept lsb is odd
        rnd_up = r.rnd && wide[31] && ((|wide[30:0]) || wide[32]);
        if (!r.lng) begin
            // word: fractions drop the duplicate sign bit
            p32 = r.frac ? wide[31:0] : m.prod[31:0];
        end else if (r.frac) begin
            p32 = wide[63:32] + {31'h0, rnd_up};
        end else begin
            p32 = m.prod[31:0];
        end
        // a left shift may drop the product msb; this is not flagged
        unique case (r.sh)
            SH_LEFT: psh = {p32[30:0], 1'b0};
            SH_RIGHT: psh = {(!r.uns && p32[31]), p32[31:1]};
            default: psh = p32; // no shift; code 3 is illegal
        endcase
        // two guard bits catch overflow in both formats
        if (r.sub) begin
            sum = {{2{!r.uns && q.acc[31]}}, q.acc}
                - {{2{!r.uns && psh[31]}}, psh};
        end else begin
            sum = {{2{!r.uns && q.acc[31]}}, q.acc}
                + {{2{!r.uns && psh[31]}}, psh};
        end
        // unsigned: any carry or borrow out; signed: guard bits and sign bit disagree
        if (r.uns) begin
            ovf = sum[33:32] != 2'h0;
            sat_val = sum[33] ? 32'h00000000 : 32'hFFFFFFFF;
        end else begin
            ovf = !(sum[33:31] == 3'h0 || sum[33:31] == 3'h7);
            sat_val = sum[33] ? 32'h80000000 : 32'h7FFFFFFF;
        end
        // wrap unless saturation was in force when the op was issued
        acc_new = (r.sat && ovf) ? sat_val : sum[31:0];
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_q = q;
        // pulses last one cycle unless set again below
        next_q.res_v = 1'b0;
        next_q.ccr_v = 1'b0;
        next_q.addr_v = 1'b0;
        next_q.s1 = '0;
        // the gap counter holds issue off after long operations
        if (q.gap != 2'h0) begin
            next_q.gap = q.gap - 2'h1;
        end

        // accumulate stage: third step of the pipe
        if (r.v && !r.mul) begin
            next_q.acc = acc_new;
            // flags from the final value, not the raw product
            next_q.sr[`SR_N] = acc_new[31];
            next_q.sr[`SR_Z] = acc_new == 32'h0;
            next_q.sr[`SR_V] = ovf;
        end else if (r.v) begin
            // integer multiply answers straight to the core
            next_q.res_v = 1'b1;
            next_q.res = m.prod[31:0];
        end

        // arithmetic issue fills the operand stage
        if (take && !is_move) begin
            // operand stage captures the mode now in force
            next_q.s1.v = 1'b1;
            next_q.s1.mul = !is_mac;
            next_q.s1.sub = ISSUE_OP == OP_MSAC;
            next_q.s1.lng = ISSUE_LONG;
            next_q.s1.sat = q.sr[`SR_SAT];
            next_q.s1.uns = op_uns;
            next_q.s1.frac = is_mac && q.sr[`SR_FRAC];
            next_q.s1.rnd = q.sr[`SR_RND];
            next_q.s1.sh = is_mac ? ISSUE_SHIFT : SH_NONE;
            next_q.s1.a = ext_a[32:0];
            next_q.s1.b = ext_b[32:0];
            if (ISSUE_LONG) begin
                next_q.gap = (is_mac && q.sr[`SR_FRAC]) ? `GAP_LONG_FRAC
                                                        : `GAP_LONG_INT;
            end
            // fetch address leaves beside the multiply
            if (is_mac && ISSUE_WITH_LOAD) begin
                next_q.addr_v = 1'b1;
                next_q.addr = ISSUE_USE_MASK
                    ? {ISSUE_ADDR[31:16], ISSUE_ADDR[15:0] & q.mask}
                    : ISSUE_ADDR;
            end
        end

        // moves are taken only with an empty pipe, so they never
        // race the accumulate stage for the same register
        if (take && is_move) begin
            unique case (ISSUE_OP)
                OP_LOAD_ACC: next_q.acc = ISSUE_OPA;
                OP_LOAD_SR: next_q.sr = ISSUE_OPA[7:0] & `SR_WMASK;
                OP_LOAD_MASK: next_q.mask = ISSUE_OPA[15:0];
                OP_STORE_ACC: begin
                    next_q.res_v = 1'b1;
                    next_q.res = q.acc;
                end
                OP_STORE_SR: begin
                    next_q.res_v = 1'b1;
                    next_q.res = {24'h0, q.sr};
                end
                OP_STORE_MASK: begin
                    next_q.res_v = 1'b1;
                    next_q.res = {16'h0, q.mask};
                end
                OP_SR_TO_CCR: begin
                    // carry bit has no source here and reads zero
                    next_q.ccr_v = 1'b1;
                    next_q.condition_code_register = {q.sr[`SR_N], q.sr[`SR_Z], q.sr[`SR_V], 1'b0};
                end
                default: next_q.res_v = 1'b0; // arithmetic ops not here
            endcase
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // reset gives the programmer-visible registers defined values
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            q <= '0;
            q.acc <= `ACC_RST;
            q.mask <= `MASK_RST;
            q.sr <= `SR_RST;
        end else begin
            q <= next_q;
        end
    end

    // result, flag and address outputs come straight from flip-flops
    assign RESULT_VALID = q.res_v;
    assign RESULT_DATA = q.res;
    assign CCR_VALID = q.ccr_v;
    assign CCR_FLAGS = q.condition_code_register;
    assign ADDR_VALID = q.addr_v;
    assign MASKED_ADDR = q.addr;

    // ****************************************
    // checks
    // ****************************************
    // issue interval checks
    a_word_rate: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && !is_move && !ISSUE_LONG |=> q.gap == 2'h0)
        else $error("word operation blocked the next issue");

    a_long_int_gap: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && ISSUE_LONG && !(is_mac && q.sr[`SR_FRAC]) && !is_move
        |=> !ISSUE_READY [*2] ##1 q.gap == 2'h0)
        else $error("long integer issue interval not three");

    a_long_frac_gap: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && ISSUE_LONG && is_mac && q.sr[`SR_FRAC]
        |=> !ISSUE_READY [*3] ##1 q.gap == 2'h0)
        else $error("long fraction issue interval not four");

    // answer timing checks
    a_mul_latency: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && !is_move && !is_mac |-> ##3 RESULT_VALID)
        else $error("multiply result not out three cycles later");

    a_load_acc: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && ISSUE_OP == OP_LOAD_ACC |=> q.acc == $past(ISSUE_OPA))
        else $error("accumulator load lost");

    a_store_acc: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && ISSUE_OP == OP_STORE_ACC
        |=> RESULT_VALID && RESULT_DATA == $past(q.acc))
        else $error("accumulator store wrong");

    a_ccr_copy: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && ISSUE_OP == OP_SR_TO_CCR
        |=> CCR_VALID && CCR_FLAGS[3:1] == $past(q.sr[3:1]))
        else $error("flags not copied to condition codes");

    // accumulate stage checks
    a_flags_final: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        r.v && !r.mul |=> q.sr[`SR_Z] == (q.acc == 32'h0) && q.sr[`SR_N] == q.acc[31])
        else $error("flags disagree with accumulator");

    a_sat_clamp: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        r.v && !r.mul && r.sat && ovf |=> q.sr[`SR_V]
        && (q.acc inside {32'h7FFFFFFF, 32'h80000000, 32'h00000000, 32'hFFFFFFFF}))
        else $error("saturation did not clamp");

    a_mask_addr: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && is_mac && ISSUE_WITH_LOAD && ISSUE_USE_MASK
        |=> ADDR_VALID && MASKED_ADDR[15:0] == ($past(ISSUE_ADDR[15:0]) & $past(q.mask)))
        else $error("operand address not masked");

    // move ordering checks: no arithmetic taken in the two edges before a move
    a_move_waits: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && is_move |-> !$past(take && !is_move) && !$past(take && !is_move, 2))
        else $error("move accepted over work in flight");

    a_mode_capture: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        take && !is_move |=> q.s1.v && q.s1.sat == $past(q.sr[`SR_SAT]) && q.s1.rnd == $past(q.sr[`SR_RND]))
        else $error("operand stage did not capture the mode in force");

    a_acc_hold: assert property (
        @(posedge CLK_SYS) disable iff (!ARST_N)
        !(r.v && !r.mul) && !(take && ISSUE_OP == OP_LOAD_ACC) |=> $stable(q.acc))
        else $error("accumulator changed without accumulate or load");
endmodule : multiply_accumulate_unit

/* hw/mac_map.svh */
// Summary of operation
// - three-stage pipeline built around 33x33 multiply
// - word MAC issues alongside a parallel fetch
// - long MAC blocks issue for two cycles, long fraction MAC for three
// - 32-bit read/write accumulator collects MAC results
// - 16-bit mask optionally masks operand address
// - flags reflect final accumulated result
// - multiply, then add or subtract into accumulator
// - product optionally shifted left or right
// - optional saturation instead of wrap
// - word and long products both 32 bits
// - long integer keeps low 32 product bits
// - long fraction truncates or rounds nearest-even
// - issue every 1, 3 or 4 clocks
// - each operand picks upper or lower half
// - status holds 4-bit operating mode field
// - status holds negative, zero, overflow flags
// - signed and unsigned integer multiplies
// - MAC with load runs beside register load
// - load accumulator from register or immediate
// - store/load of accumulator, status, mask
// - copy status flags into condition codes
// - results stay in accumulator until moved
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH
// status register field positions
`define SR_SAT 7
`define SR_UNS 6
`define SR_FRAC 5
`define SR_RND 4
`define SR_N 3
`define SR_Z 2
`define SR_V 1
// bit 0 is reserved and reads as zero
`define SR_WMASK 8'hFE
// reset values
`define ACC_RST 32'h00000000
`define MASK_RST 16'hFFFF
`define SR_RST 8'h00
// extra blocked cycles after a long issue
`define GAP_LONG_INT 2'h2
`define GAP_LONG_FRAC 2'h3
`endif

/* hw/mac_pkg.sv */
package mac_pkg;
    // instructions the issuing pipeline may hand over
    typedef enum logic [3:0] {
        OP_MAC, OP_MSAC, OP_MULS, OP_MULU,
        OP_LOAD_ACC, OP_LOAD_SR, OP_LOAD_MASK,
        OP_STORE_ACC, OP_STORE_SR, OP_STORE_MASK,
        OP_SR_TO_CCR
    } op_e;
    // product shift before accumulation
    typedef enum logic [1:0] {SH_NONE, SH_LEFT, SH_RIGHT} shift_e;
    // one instruction moving down the arithmetic pipe
    typedef struct packed {
        logic v;
        logic mul;
        logic sub;
        logic lng;
        logic sat;
        logic uns;
        logic frac;
        logic rnd;
        shift_e sh;
        logic [32:0] a;
        logic [32:0] b;
    } stage_s;
endpackage : mac_pkg

/* hw/mac_if.sv */
`timescale 1ns/1ps
// link between operand stage and product stage
interface mac_if;
    import mac_pkg::*;
    mac_pkg::stage_s req; // operands going in
    mac_pkg::stage_s res; // instruction leaving the array
    logic [63:0] prod; // registered product
    modport feed (output req, input res, input prod);
    modport mult (input req, output res, output prod);
endinterface : mac_if

/* hw/mac_product.sv */
`timescale 1ns/1ps
`include "mac_map.svh"
module mac_product import mac_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    mac_if.mult m
);
    // ****************************************
    // product stage state
    // ****************************************
    typedef struct packed {
        stage_s info;
        logic [63:0] prod;
    } mstate_s;
    mstate_s q; // registered stage
    mstate_s next_q; // next value

    // one wide multiply per cycle; the extend bit carries signedness
    always_comb begin
        next_q = q;
        next_q.info = m.req;
        next_q.prod = 64'(signed'(m.req.a) * signed'(m.req.b));
    end

    // register the product stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign m.res = q.info;
    assign m.prod = q.prod;

    a_prod_stage: assert property (
        @(posedge clk) disable iff (!arst_n)
        m.req.v |=> m.res.v && m.prod == 64'(signed'($past(m.req.a)) * signed'($past(m.req.b))))
        else $error("product stage lost or altered an operation");
endmodule : mac_product

/* tb/issue_model.sv */
`timescale 1ns/1ps
// ****************************************************
// issuing pipeline model: offers one instruction at a time
// ****************************************************
module issue_model import mac_pkg::*; (
    input wire logic clk,
    input wire logic ready,
    output logic valid,
    output op_e op,
    output logic lng,
    output logic hi_a,
    output logic hi_b,
    output shift_e sh,
    output logic [31:0] opa,
    output logic [31:0] opb,
    output logic with_load,
    output logic use_mask,
    output logic [31:0] addr,
    output int cyc,
    output int t_take
);
    // quiet bus at time zero
    initial begin
        valid = 1'b0;
        op = OP_LOAD_ACC;
        sh = SH_NONE;
        {lng, hi_a, hi_b, with_load, use_mask} = '0;
        {opa, opb, addr} = '0;
        t_take = 0;
    end
    // free cycle count, used to time answers
    always @(posedge clk) cyc <= cyc + 1;
    // offer held until ready is seen at an edge; left asserted for back-to-back use
    task automatic send(input op_e o, input logic l, input logic ha, input logic hb, input shift_e s,
                        input logic [31:0] a, input logic [31:0] b, input logic wl, input logic um,
                        input logic [31:0] ad);
        bit got;
        got = 1'b0;
        op = o;
        sh = s;
        {lng, hi_a, hi_b} = {l, ha, hb};
        {opa, opb} = {a, b};
        {with_load, use_mask, addr} = {wl, um, ad};
        valid = 1'b1;
        // ready is combinational: judge it mid-cycle when settled
        while (!got) begin
            @(negedge clk);
            got = (ready === 1'b1);
            // t_take names the cycle in which the offer was taken
            t_take = cyc;
            @(posedge clk);
        end
        #1;
    endtask : send
    // release; lines flip so no stale value passes for data
    task automatic idle;
        valid = 1'b0;
        opa = ~opa;
        opb = ~opb;
        addr = ~addr;
        @(posedge clk);
        #1;
    endtask : idle
endmodule : issue_model

/* tb/tb.sv */
`timescale 1ns/1ps
// ****************
// single comparison
// ****************
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module tb import mac_pkg::*; ;
    logic clk;
    logic arst_n;
    logic iv, il, iha, ihb, iwl, ium, rdy, rv, cv, av;
    op_e iop;
    shift_e ish;
    logic [31:0] ia, ib, iad, rd, ma;
    logic [3:0] cf;
    int cyc, t_take;
    int miscompares = 0;
    int n_compared = 0;

    multiply_accumulate_unit i_dut (.CLK_SYS(clk), .ARST_N(arst_n), .ISSUE_VALID(iv), .ISSUE_OP(iop),
        .ISSUE_LONG(il), .ISSUE_HI_A(iha), .ISSUE_HI_B(ihb), .ISSUE_SHIFT(ish), .ISSUE_OPA(ia),
        .ISSUE_OPB(ib), .ISSUE_WITH_LOAD(iwl), .ISSUE_USE_MASK(ium), .ISSUE_ADDR(iad), .ISSUE_READY(rdy),
        .RESULT_VALID(rv), .RESULT_DATA(rd), .CCR_VALID(cv), .CCR_FLAGS(cf), .ADDR_VALID(av),
        .MASKED_ADDR(ma));
    issue_model i_iss (.clk(clk), .ready(rdy), .valid(iv), .op(iop), .lng(il), .hi_a(iha), .hi_b(ihb),
        .sh(ish), .opa(ia), .opb(ib), .with_load(iwl), .use_mask(ium), .addr(iad), .cyc(cyc),
        .t_take(t_take));

    // ****************
    // shared tasks
    // ****************
    // waits for a pulse (0 result, 1 flags, 2 address) and checks its cycle and value
    task automatic wait_out(input int sel, input int at, input logic [31:0] exp);
        int n;
        logic vld;
        logic [31:0] got;
        n = -1;
        got = 'x;
        for (int i = 0; i < 8 && n < 0; i++) begin
            @(negedge clk);
            vld = (sel == 0) ? rv : (sel == 1) ? cv : av;
            if (vld === 1'b1) begin
                n = cyc;
                got = (sel == 0) ? rd : (sel == 1) ? {28'h0, cf} : ma;
            end
        end
        `CHK(n, at)
        `CHK(got, exp)
        @(posedge clk);
        #1;
    endtask : wait_out
    // register move, then release
    task automatic mv(input op_e o, input logic [31:0] v);
        i_iss.send(o, 1'b0, 1'b0, 1'b0, SH_NONE, v, 32'h0, 1'b0, 1'b0, 32'h0);
        i_iss.idle();
    endtask : mv
    // arithmetic offer left asserted so the next one follows at once
    task automatic ar(input op_e o, input logic l, input logic ha, input logic hb, input shift_e s,
                      input logic [31:0] a, input logic [31:0] b);
        i_iss.send(o, l, ha, hb, s, a, b, 1'b0, 1'b0, 32'h0);
    endtask : ar
    // move with an answer: watch for the pulse while the offer is released
    task automatic store_chk(input op_e o, input logic [31:0] exp, input int sel = 0);
        i_iss.send(o, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h0, 32'h0, 1'b0, 1'b0, 32'h0);
        fork
            wait_out(sel, t_take + 1, exp);
            i_iss.idle();
        join
    endtask : store_chk

    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        store_chk(OP_STORE_ACC, 32'h00000000);
        store_chk(OP_STORE_MASK, 32'h0000FFFF);
        store_chk(OP_STORE_SR, 32'h00000000);
    endtask : t_reset
    task automatic t_moves;
        mv(OP_LOAD_ACC, 32'hA5A50F0F);
        store_chk(OP_STORE_ACC, 32'hA5A50F0F);
        mv(OP_LOAD_MASK, 32'h00001234);
        store_chk(OP_STORE_MASK, 32'h00001234);
        mv(OP_LOAD_SR, 32'h000000FF);
        // bit 0 is reserved and must read back as zero
        store_chk(OP_STORE_SR, 32'h000000FE);
        mv(OP_LOAD_SR, 32'h0);
    endtask : t_moves
    task automatic t_mul;
        int t1;
        ar(OP_MULS, 1'b0, 1'b1, 1'b1, SH_NONE, 32'hFFFE1234, 32'h00037777);
        t1 = t_take;
        ar(OP_MULU, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h1234FFFF, 32'hFFFE0002);
        i_iss.idle();
        `CHK(t_take - t1, 1)
        wait_out(0, t1 + 3, 32'hFFFFFFFA);
        wait_out(0, t1 + 4, 32'h0001FFFE);
        ar(OP_MULS, 1'b1, 1'b0, 1'b0, SH_NONE, 32'h00010003, 32'h00020001);
        i_iss.idle();
        wait_out(0, t_take + 3, 32'h00070003);
        ar(OP_MULU, 1'b1, 1'b0, 1'b0, SH_NONE, 32'h00010003, 32'h00020001);
        t1 = t_take;
        ar(OP_MULU, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h0, 32'h0);
        i_iss.idle();
        `CHK(t_take - t1, 3)
        wait_out(0, t_take + 3, 32'h0);
    endtask : t_mul
    task automatic t_mac;
        mv(OP_LOAD_ACC, 32'h0000000A);
        ar(OP_MAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h00000003, 32'h00000004);
        ar(OP_MSAC, 1'b0, 1'b1, 1'b1, SH_LEFT, 32'h00020000, 32'h00030000);
        ar(OP_MAC, 1'b0, 1'b0, 1'b1, SH_RIGHT, 32'h00000005, 32'h00020000);
        i_iss.idle();
        // 10 + 12 - 12 + 5
        store_chk(OP_STORE_ACC, 32'h0000000F);
        store_chk(OP_STORE_SR, 32'h00000000);
    endtask : t_mac
    task automatic t_sat;
        mv(OP_LOAD_SR, 32'h00000080);
        mv(OP_LOAD_ACC, 32'h7FFFFFF0);
        ar(OP_MAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h00000100, 32'h00000100);
        i_iss.idle();
        store_chk(OP_STORE_ACC, 32'h7FFFFFFF);
        store_chk(OP_STORE_SR, 32'h00000082);
        store_chk(OP_SR_TO_CCR, 32'h00000002, 1);
        mv(OP_LOAD_SR, 32'h000000C0);
        mv(OP_LOAD_ACC, 32'h00000005);
        ar(OP_MSAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h00000003, 32'h00000004);
        i_iss.idle();
        // unsigned borrow clamps at zero
        store_chk(OP_STORE_ACC, 32'h00000000);
        store_chk(OP_STORE_SR, 32'h000000C6);
    endtask : t_sat
    task automatic t_frac;
        int t1;
        mv(OP_LOAD_ACC, 32'h0);
        mv(OP_LOAD_SR, 32'h00000030);
        ar(OP_MAC, 1'b1, 1'b0, 1'b0, SH_NONE, 32'h40000000, 32'h00000003);
        t1 = t_take;
        ar(OP_MAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h0, 32'h0);
        i_iss.idle();
        `CHK(t_take - t1, 4)
        // exact tie with odd lsb rounds up to 2
        store_chk(OP_STORE_ACC, 32'h00000002);
        mv(OP_LOAD_SR, 32'h00000020);
        ar(OP_MAC, 1'b1, 1'b0, 1'b0, SH_NONE, 32'h40000000, 32'h00000003);
        i_iss.idle();
        // new mode truncates: adds 1
        store_chk(OP_STORE_ACC, 32'h00000003);
        mv(OP_LOAD_SR, 32'h0);
    endtask : t_frac
    task automatic t_mask;
        mv(OP_LOAD_MASK, 32'h000000F0);
        i_iss.send(OP_MAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h0, 32'h0, 1'b1, 1'b1, 32'h12345678);
        fork
            wait_out(2, t_take + 1, 32'h12340070);
            i_iss.idle();
        join
        i_iss.send(OP_MSAC, 1'b0, 1'b0, 1'b0, SH_NONE, 32'h0, 32'h0, 1'b1, 1'b0, 32'h0000ABCD);
        fork
            wait_out(2, t_take + 1, 32'h0000ABCD);
            i_iss.idle();
        join
    endtask : t_mask

    // ****************
    // run control
    // ****************
    task automatic give_verdict;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // reset, then every scenario in turn
    initial begin
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_moves();
        t_mul();
        t_mac();
        t_sat();
        t_frac();
        t_mask();
        give_verdict();
    end
    // the scenarios need under two hundred cycles; fifteen times that means a hang
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
endmodule : tb
